// [shared/bba_pkg.sv]
// Constants shared by the arbiter end and the master end of the byte bus.
// Assumes one bus clock and a synchronous active-low reset for all agents.
package bba_pkg;

	// ----------------------------------------------------------------
	// Bus widths and agent count
	// ----------------------------------------------------------------
	localparam int NUM_MASTERS = 2;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int SIZE_W = 2;
	localparam int MAX_BYTES = 8;
	localparam int CNT_W = 4;

	// ----------------------------------------------------------------
	// Size field encodings
	// ----------------------------------------------------------------
	localparam logic [SIZE_W-1:0] SIZE_1B = 2'h0;
	localparam logic [SIZE_W-1:0] SIZE_2B = 2'h1;
	localparam logic [SIZE_W-1:0] SIZE_4B = 2'h2;
	localparam logic [SIZE_W-1:0] SIZE_8B = 2'h3;

	// ----------------------------------------------------------------
	// Reset values and the one-count step
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_IDLE = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

endpackage

// [shared/bba_if.sv]
// Shared byte bus: arbitration lines, per-agent drive values and the resolved bus.
// Assumes the testbench drives the slave lines (slvData, slvDataOeN, waitLine, errorLine).
`timescale 1ns/100ps
interface bba_if;

	// ----------------------------------------------------------------
	// Arbitration lines: a request and a grant per master, one shared start
	// ----------------------------------------------------------------
	logic req [bba_pkg::NUM_MASTERS];
	logic [bba_pkg::NUM_MASTERS-1:0] gnt;
	logic start;

	// ----------------------------------------------------------------
	// Drive values; an enable is low while its owner drives
	// ----------------------------------------------------------------
	logic [bba_pkg::ADDR_W-1:0] mAddr [bba_pkg::NUM_MASTERS];
	logic [bba_pkg::SIZE_W-1:0] mSize [bba_pkg::NUM_MASTERS];
	logic mRead [bba_pkg::NUM_MASTERS];
	logic mWrite [bba_pkg::NUM_MASTERS];
	logic mAddrOeN [bba_pkg::NUM_MASTERS];
	logic mBip [bba_pkg::NUM_MASTERS];
	logic mBipOeN [bba_pkg::NUM_MASTERS];
	logic [bba_pkg::DATA_W-1:0] mData [bba_pkg::NUM_MASTERS];
	logic mDataOeN [bba_pkg::NUM_MASTERS];
	logic arbAddrOeN;
	logic [bba_pkg::DATA_W-1:0] slvData;
	logic slvDataOeN;
	logic waitLine;
	logic errorLine;

	// ----------------------------------------------------------------
	// Resolved bus; undriven lines read as zero
	// ----------------------------------------------------------------
	logic [bba_pkg::ADDR_W-1:0] addr;
	logic [bba_pkg::SIZE_W-1:0] size;
	logic read;
	logic write;
	logic bip;
	logic [bba_pkg::DATA_W-1:0] data;

	always_comb begin
		addr = bba_pkg::ADDR_IDLE;
		size = bba_pkg::SIZE_1B;
		read = 1'b0;
		write = 1'b0;
		bip = 1'b0;
		data = slvDataOeN ? bba_pkg::DATA_IDLE : slvData;
		for (int i = 0; i < bba_pkg::NUM_MASTERS; i++) begin
			if (!mAddrOeN[i]) begin
				addr = addr | mAddr[i];
				size = size | mSize[i];
				read = read | mRead[i];
				write = write | mWrite[i];
			end
			if (!mBipOeN[i]) begin
				bip = bip | mBip[i];
			end
			if (!mDataOeN[i]) begin
				data = data | mData[i];
			end
		end
	end

	modport arb (
		input req,
		input bip,
		input waitLine,
		input errorLine,
		output gnt,
		output start,
		output arbAddrOeN
	);

	modport mst (
		input gnt,
		input data,
		input waitLine,
		input errorLine,
		output req,
		output mAddr,
		output mSize,
		output mRead,
		output mWrite,
		output mAddrOeN,
		output mBip,
		output mBipOeN,
		output mData,
		output mDataOeN
	);

endinterface

// [hw/bba_arbiter.sv]
// Central arbiter of the byte bus: start pulse, fixed-priority grants, idle address phase.
// Assumes masters and the slave run on clk; idle address lines resolve to zero in the interface.
`timescale 1ns/100ps
module bba_arbiter (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus side
	bba_if.arb bus,
	// Observation side
	output logic [bba_pkg::NUM_MASTERS-1:0] lastGnt,
	output logic idlePhase
);

	// ----------------------------------------------------------------
	// Phase tracking
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		A_RST = 2'b00,
		A_ARB = 2'b01,
		A_ADDR = 2'b10,
		A_DATA = 2'b11
	} bba_aphase_e;

	bba_aphase_e stateFf;
	bba_aphase_e nxt_state;
	logic startFf;
	logic nopFf;
	logic arbOeNFf;
	logic [bba_pkg::NUM_MASTERS-1:0] gntFf;
	logic [bba_pkg::NUM_MASTERS-1:0] lastGntFf;
	logic idleFf;

	// Lowest index wins.
	function automatic logic [bba_pkg::NUM_MASTERS-1:0] pickOne(input logic r [bba_pkg::NUM_MASTERS]);
		logic [bba_pkg::NUM_MASTERS-1:0] g;
		g = '0;
		for (int i = bba_pkg::NUM_MASTERS - 1; i >= 0; i--) begin
			if (r[i]) begin
				g = '0;
				g[i] = 1'b1;
			end
		end
		return g;
	endfunction

	wire anyGnt = |gntFf;
	wire [bba_pkg::NUM_MASTERS-1:0] choice = pickOne(bus.req);
	wire lastData = bus.errorLine || (!bus.bip && !bus.waitLine);
	wire nxtStart = (stateFf == A_RST) || (stateFf == A_ADDR && nopFf) || (stateFf == A_DATA && lastData);

	always_comb begin
		case (stateFf)
			A_RST: nxt_state = A_ARB;
			A_ARB: nxt_state = A_ADDR;
			A_ADDR: nxt_state = nopFf ? A_ARB : A_DATA;
			A_DATA: nxt_state = lastData ? A_ARB : A_DATA;
			default: nxt_state = A_RST;
		endcase
	end

	// ----------------------------------------------------------------
	// Rising-edge registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stateFf <= A_RST;
			startFf <= 1'b0;
			nopFf <= 1'b0;
			arbOeNFf <= 1'b1;
			lastGntFf <= '0;
			idleFf <= 1'b0;
		end else begin
			stateFf <= nxt_state;
			startFf <= nxtStart;
			nopFf <= (stateFf == A_ARB) && !anyGnt;
			arbOeNFf <= !((stateFf == A_ARB) && !anyGnt);
			idleFf <= (stateFf == A_ARB) && !anyGnt;
			if (stateFf == A_ARB && anyGnt) begin
				lastGntFf <= gntFf;
			end
		end
	end

	// ----------------------------------------------------------------
	// Falling-edge grant
	// ----------------------------------------------------------------
	always_ff @(negedge clk) begin
		if (!resetn) begin
			gntFf <= '0;
		end else begin
			gntFf <= startFf ? choice : '0;
		end
	end

	assign bus.start = startFf;
	assign bus.gnt = gntFf;
	assign bus.arbAddrOeN = arbOeNFf;
	assign lastGnt = lastGntFf;
	assign idlePhase = idleFf;

endmodule

// [hw/bba_master.sv]
// One bus master of the byte bus: requests, drives address phase and write data, takes read data.
// Assumes the arbiter grants on the falling edge and the slave answers with wait and error lines.
`timescale 1ns/100ps
module bba_master #(
	parameter int IDX = 0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus side
	bba_if.mst bus,
	// Command from user logic
	input wire logic cmdValid,
	input wire logic cmdRead,
	input wire logic [bba_pkg::ADDR_W-1:0] cmdAddr,
	input wire logic [bba_pkg::SIZE_W-1:0] cmdSize,
	input wire logic [bba_pkg::MAX_BYTES*bba_pkg::DATA_W-1:0] cmdWrData,
	output logic cmdReady,
	// Results to user logic
	output logic [bba_pkg::DATA_W-1:0] rdData,
	output logic rdValid,
	output logic xferDone,
	output logic xferErr
);

	// ----------------------------------------------------------------
	// State and registers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_REQ = 2'b01,
		M_ADDR = 2'b10,
		M_DATA = 2'b11
	} bba_mstate_e;

	localparam int BUF_W = bba_pkg::MAX_BYTES * bba_pkg::DATA_W;

	bba_mstate_e stateFf, nxt_state;
	logic reqFf, nxt_req;
	logic readyFf, nxt_ready;
	logic isReadFf, nxt_isRead;
	logic [bba_pkg::ADDR_W-1:0] addrFf, nxt_addr;
	logic [bba_pkg::SIZE_W-1:0] sizeFf, nxt_size;
	logic [bba_pkg::CNT_W-1:0] leftFf, nxt_left;
	logic [BUF_W-1:0] bufFf, nxt_buf;
	logic addrOeNFf, nxt_addrOeN;
	logic bipFf, nxt_bip;
	logic bipOeNFf, nxt_bipOeN;
	logic dataOeNFf, nxt_dataOeN;
	logic [bba_pkg::DATA_W-1:0] rdDataFf, nxt_rdData;
	logic rdValidFf, nxt_rdValid;
	logic doneFf, nxt_done;
	logic errFf, nxt_err;

	// Burst length from the size code: 1, 2, 4 or 8 bytes.
	function automatic logic [bba_pkg::CNT_W-1:0] burstLen(input logic [bba_pkg::SIZE_W-1:0] s);
		case (s)
			bba_pkg::SIZE_1B: return 4'h1;
			bba_pkg::SIZE_2B: return 4'h2;
			bba_pkg::SIZE_4B: return 4'h4;
			bba_pkg::SIZE_8B: return 4'h8;
			default: return 4'h1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire granted = bus.gnt[IDX];
	wire takeCmd = (stateFf == M_IDLE) && readyFf && cmdValid;
	wire lastCyc = bus.errorLine || (!bipFf && !bus.waitLine);
	wire byteOk = !bus.waitLine && !bus.errorLine;
	wire [bba_pkg::CNT_W-1:0] leftAfter = leftFf - bba_pkg::CNT_ONE;
	wire [bba_pkg::CNT_W-1:0] firstLeft = burstLen(sizeFf);

	always_comb begin
		nxt_state = stateFf;
		nxt_req = reqFf;
		nxt_ready = readyFf;
		nxt_isRead = isReadFf;
		nxt_addr = addrFf;
		nxt_size = sizeFf;
		nxt_left = leftFf;
		nxt_buf = bufFf;
		nxt_addrOeN = 1'b1;
		nxt_bip = 1'b0;
		nxt_bipOeN = 1'b1;
		nxt_dataOeN = 1'b1;
		nxt_rdData = rdDataFf;
		nxt_rdValid = 1'b0;
		nxt_done = 1'b0;
		nxt_err = errFf;
		case (stateFf)
			M_IDLE: begin
				if (takeCmd) begin
					// Only ask for the bus with a complete transfer in hand.
					nxt_state = M_REQ;
					nxt_req = 1'b1;
					nxt_ready = 1'b0;
					nxt_isRead = cmdRead;
					nxt_addr = cmdAddr;
					nxt_size = cmdSize;
					nxt_buf = cmdWrData;
				end
			end
			M_REQ: begin
				if (granted) begin
					nxt_state = M_ADDR;
					nxt_req = 1'b0;
					nxt_addrOeN = 1'b0;
				end
			end
			M_ADDR: begin
				// Data phase starts right after the single address cycle.
				nxt_state = M_DATA;
				nxt_left = firstLeft;
				nxt_bip = firstLeft > bba_pkg::CNT_ONE;
				nxt_bipOeN = 1'b0;
				nxt_dataOeN = isReadFf;
			end
			M_DATA: begin
				if (isReadFf && byteOk) begin
					nxt_rdData = bus.data;
					nxt_rdValid = 1'b1;
				end
				if (lastCyc) begin
					nxt_state = M_IDLE;
					nxt_ready = 1'b1;
					nxt_done = 1'b1;
					nxt_err = bus.errorLine;
				end else begin
					nxt_bipOeN = 1'b0;
					nxt_dataOeN = isReadFf;
					nxt_bip = bipFf;
					if (!bus.waitLine) begin
						nxt_left = leftAfter;
						nxt_buf = bufFf >> bba_pkg::DATA_W;
						nxt_bip = leftAfter > bba_pkg::CNT_ONE;
					end
				end
			end
			default: begin
				nxt_state = M_IDLE;
				nxt_ready = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stateFf <= M_IDLE;
			reqFf <= 1'b0;
			readyFf <= 1'b1;
			isReadFf <= 1'b0;
			addrFf <= bba_pkg::ADDR_IDLE;
			sizeFf <= bba_pkg::SIZE_1B;
			leftFf <= bba_pkg::CNT_ZERO;
			bufFf <= '0;
			addrOeNFf <= 1'b1;
			bipFf <= 1'b0;
			bipOeNFf <= 1'b1;
			dataOeNFf <= 1'b1;
			rdDataFf <= bba_pkg::DATA_IDLE;
			rdValidFf <= 1'b0;
			doneFf <= 1'b0;
			errFf <= 1'b0;
		end else begin
			stateFf <= nxt_state;
			reqFf <= nxt_req;
			readyFf <= nxt_ready;
			isReadFf <= nxt_isRead;
			addrFf <= nxt_addr;
			sizeFf <= nxt_size;
			leftFf <= nxt_left;
			bufFf <= nxt_buf;
			addrOeNFf <= nxt_addrOeN;
			bipFf <= nxt_bip;
			bipOeNFf <= nxt_bipOeN;
			dataOeNFf <= nxt_dataOeN;
			rdDataFf <= nxt_rdData;
			rdValidFf <= nxt_rdValid;
			doneFf <= nxt_done;
			errFf <= nxt_err;
		end
	end

	// ----------------------------------------------------------------
	// Bus drive; read and write are only asserted with the address enable
	// ----------------------------------------------------------------
	assign bus.req[IDX] = reqFf;
	assign bus.mAddr[IDX] = addrFf;
	assign bus.mSize[IDX] = sizeFf;
	assign bus.mRead[IDX] = isReadFf && !addrOeNFf;
	assign bus.mWrite[IDX] = !isReadFf && !addrOeNFf;
	assign bus.mAddrOeN[IDX] = addrOeNFf;
	assign bus.mBip[IDX] = bipFf;
	assign bus.mBipOeN[IDX] = bipOeNFf;
	assign bus.mData[IDX] = bufFf[bba_pkg::DATA_W-1:0];
	assign bus.mDataOeN[IDX] = dataOeNFf;

	assign cmdReady = readyFf;
	assign rdData = rdDataFf;
	assign rdValid = rdValidFf;
	assign xferDone = doneFf;
	assign xferErr = errFf;

endmodule

// [test/bba_bus_chk.sv]
// Concurrent checks on the shared byte bus: start pulse, grants and phase ownership.
// Assumes it sits beside the bus interface with every input tied to the signal of the same name.
`timescale 1ns/100ps
module bba_bus_chk (
	// Clock and reset
	input logic clk,
	input logic resetn,
	// Arbitration
	input logic start,
	input logic [bba_pkg::NUM_MASTERS-1:0] gnt,
	input logic arbAddrOeN,
	// Resolved bus
	input logic [bba_pkg::ADDR_W-1:0] addr,
	input logic [bba_pkg::SIZE_W-1:0] size,
	input logic read,
	input logic write,
	input logic bip,
	input logic waitLine,
	input logic errorLine
);
	logic prevStart_ff;
	logic dataPh_ff;
	logic nxt_dataPh;
	logic lastData;

	// A data phase follows a real address phase and runs until its last cycle.
	assign lastData = dataPh_ff && (errorLine || (!bip && !waitLine));
	assign nxt_dataPh = (prevStart_ff && (read || write)) || (dataPh_ff && !lastData);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prevStart_ff <= 1'b0;
			dataPh_ff <= 1'b0;
		end else begin
			prevStart_ff <= start;
			dataPh_ff <= nxt_dataPh;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_start_pulse: assert property (start |=> !start)
		else $error("start high for two cycles");
	a_start_after_end: assert property (lastData |=> start)
		else $error("no arbitration after last data cycle");
	a_start_after_idle: assert property (prevStart_ff && !read && !write |=> start)
		else $error("no arbitration after idle address phase");
	a_start_low_data: assert property (dataPh_ff && !lastData |=> !start)
		else $error("start raised inside a data phase");
	a_gnt_single: assert property ($onehot0(gnt))
		else $error("more than one grant high");
	a_gnt_in_arb: assert property (gnt != '0 |-> start)
		else $error("grant high outside arbitration");
	a_gnt_one_cycle: assert property (gnt != '0 |=> gnt == '0)
		else $error("grant held too long");
	a_idle_lines: assert property (start && gnt == '0 |=>
		!arbAddrOeN && addr == '0 && size == '0 && !read && !write)
		else $error("idle address phase not driven to zero");
	a_master_addr: assert property (gnt != '0 |=> (read ^ write) && arbAddrOeN)
		else $error("granted master gave no address phase");
	a_data_quiet: assert property (dataPh_ff |-> !read && !write && addr == '0)
		else $error("address lines driven in data phase");
	a_bus_release: assert property (lastData |=> !bip && !read && !write)
		else $error("bus not released after transfer");
	a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !start && gnt == '0)
		else $error("start or grant high in reset");
	a_reset_start: assert property (disable iff (1'b0) !resetn ##1 resetn |=> start)
		else $error("no start after reset release");
endmodule

// [test/byte_bus_arbiter_protocol_tb.sv]
// Self-checking bench: one arbiter and two masters on the byte bus, the slave played by the bench.
// Assumes the package, the interface and both design modules are compiled before it.
`timescale 1ns/100ps
module byte_bus_arbiter_protocol_tb;
	localparam int NM = bba_pkg::NUM_MASTERS;
	localparam logic [63:0] PAT [2] = '{64'h8877665544332211, 64'hf1e2d3c4b5a69788};
	logic clk;
	logic resetn;
	logic cmdValid [NM];
	logic cmdRead [NM];
	logic [bba_pkg::ADDR_W-1:0] cmdAddr [NM];
	logic [bba_pkg::SIZE_W-1:0] cmdSize [NM];
	logic [bba_pkg::MAX_BYTES*bba_pkg::DATA_W-1:0] cmdWrData [NM];
	logic cmdReady [NM];
	logic [bba_pkg::DATA_W-1:0] rdData [NM];
	logic rdValid [NM];
	logic xferDone [NM];
	logic xferErr [NM];
	logic [NM-1:0] lastGnt;
	logic idlePhase;
	logic [7:0] rdQ [$];
	logic errQ [$];
	int errors;
	int n_tests;
	int cyc;

	bba_if bus ();
	bba_arbiter bba_arbiter_i (.clk(clk), .resetn(resetn), .bus(bus), .lastGnt(lastGnt), .idlePhase(idlePhase));
	for (genvar g = 0; g < NM; g++) begin : gm
		bba_master #(.IDX(g)) bba_master_i (.clk(clk), .resetn(resetn), .bus(bus), .cmdValid(cmdValid[g]),
			.cmdRead(cmdRead[g]), .cmdAddr(cmdAddr[g]), .cmdSize(cmdSize[g]), .cmdWrData(cmdWrData[g]),
			.cmdReady(cmdReady[g]), .rdData(rdData[g]), .rdValid(rdValid[g]), .xferDone(xferDone[g]),
			.xferErr(xferErr[g]));
	end
	bba_bus_chk bba_bus_chk_i (.clk(clk), .resetn(resetn), .start(bus.start), .gnt(bus.gnt),
		.arbAddrOeN(bus.arbAddrOeN), .addr(bus.addr), .size(bus.size), .read(bus.read), .write(bus.write),
		.bip(bus.bip), .waitLine(bus.waitLine), .errorLine(bus.errorLine));

	always #5 clk = ~clk;

	// Collects read bytes and transfer results; also cuts a hang short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		for (int m = 0; m < NM; m++) begin
			if (rdValid[m] === 1'b1) rdQ.push_back(rdData[m]);
			if (xferDone[m] === 1'b1) errQ.push_back(xferErr[m]);
		end
		if (cyc == 3000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic issue(input logic [NM-1:0] mask, input logic rd, input logic [1:0] sz);
		@(posedge clk);
		for (int m = 0; m < NM; m++) begin
			cmdValid[m] <= mask[m];
			cmdRead[m] <= rd;
			cmdSize[m] <= sz;
			cmdAddr[m] <= 16'h4a00 + 16'(m);
		end
		@(posedge clk);
		for (int m = 0; m < NM; m++) cmdValid[m] <= 1'b0;
	endtask

	// Plays the slave: waits before the first byte, fails byte errAt, checks what the master drives.
	task automatic slave(input int m, input logic rd, input logic [1:0] sz, input int waits, input int errAt);
		int nb;
		int b;
		int w;
		int i;
		logic busy;
		nb = 1 << sz;
		b = 0;
		w = 0;
		i = 0;
		busy = 1'b1;
		while (!(bus.read || bus.write) && i < 100) begin
			@(posedge clk);
			i++;
		end
		chk("addr", 16'h4a00 + m, bus.addr);
		chk("size", sz, bus.size);
		chk("read", rd, bus.read);
		chk("write", !rd, bus.write);
		while (busy) begin
			bus.waitLine <= (w < waits);
			bus.errorLine <= (w >= waits) && (b == errAt);
			bus.slvDataOeN <= !rd || (w < waits);
			bus.slvData <= PAT[m][8*b +: 8];
			@(posedge clk);
			if (!rd) chk("write data", PAT[m][8*b +: 8], bus.data);
			chk("bip", b < nb - 1, bus.bip);
			if (w < waits) w++;
			else if (b == errAt || b == nb - 1) busy = 1'b0;
			else b++;
		end
		bus.waitLine <= 1'b0;
		bus.errorLine <= 1'b0;
		bus.slvDataOeN <= 1'b1;
	endtask

	task automatic settle(input int m, input logic rd, input int nbOk, input logic err);
		repeat (2) @(posedge clk);
		chk("done count", 1, errQ.size());
		if (errQ.size() > 0) chk("error status", err, errQ.pop_front());
		chk("read count", rd ? nbOk : 0, rdQ.size());
		for (int b = 0; b < nbOk && rd && rdQ.size() > 0; b++) chk("read data", PAT[m][8*b +: 8], rdQ.pop_front());
		rdQ.delete();
	endtask

	task automatic xfer(input int m, input logic rd, input logic [1:0] sz, input int waits, input int errAt);
		issue(NM'(1 << m), rd, sz);
		slave(m, rd, sz, waits, errAt);
		settle(m, rd, (errAt < (1 << sz)) ? errAt : (1 << sz), errAt < (1 << sz));
	endtask

	task automatic test_idle();
		int i;
		i = 0;
		while (idlePhase !== 1'b1 && i < 10) begin
			@(posedge clk);
			i++;
		end
		chk("idle phase", 1, idlePhase);
		chk("idle addr", 0, bus.addr);
		@(posedge clk);
		chk("start after idle", 1, bus.start);
	endtask

	task automatic test_sizes();
		for (int sz = 0; sz < 4; sz++) xfer(0, 1'b0, 2'(sz), sz, 99);
		xfer(1, 1'b1, 2'h1, 2, 99);
		xfer(1, 1'b1, 2'h3, 0, 99);
	endtask

	task automatic test_errors();
		xfer(0, 1'b0, 2'h2, 0, 1);
		xfer(1, 1'b1, 2'h2, 1, 2);
	endtask

	task automatic test_both();
		issue(2'h3, 1'b0, 2'h0);
		slave(0, 1'b0, 2'h0, 0, 99);
		chk("first grant", 2'h1, lastGnt);
		settle(0, 1'b0, 1, 1'b0);
		slave(1, 1'b0, 2'h0, 1, 99);
		chk("second grant", 2'h2, lastGnt);
		settle(1, 1'b0, 1, 1'b0);
	endtask

	// Cuts a write burst with a reset in its data phase; the bus must restart cleanly.
	task automatic test_reset();
		int i;
		i = 0;
		issue(2'h1, 1'b0, 2'h3);
		while (!(bus.read || bus.write) && i < 100) begin
			@(posedge clk);
			i++;
		end
		chk("ready while busy", 0, cmdReady[0]);
		bus.waitLine <= 1'b1;
		@(posedge clk);
		resetn <= 1'b0;
		bus.waitLine <= 1'b0;
		repeat (3) @(posedge clk);
		chk("start in reset", 0, bus.start);
		chk("grant in reset", 0, bus.gnt);
		chk("ready in reset", 1, cmdReady[0]);
		resetn <= 1'b1;
		@(posedge clk);
		chk("start at release", 0, bus.start);
		@(posedge clk);
		chk("start after release", 1, bus.start);
		chk("cut transfer done", 0, errQ.size());
		xfer(1, 1'b1, 2'h0, 0, 99);
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		errors = 0;
		n_tests = 0;
		cyc = 0;
		bus.slvData = 8'h00;
		bus.slvDataOeN = 1'b1;
		bus.waitLine = 1'b0;
		bus.errorLine = 1'b0;
		for (int m = 0; m < NM; m++) begin
			cmdValid[m] = 1'b0;
			cmdRead[m] = 1'b0;
			cmdAddr[m] = 16'h0000;
			cmdSize[m] = 2'h0;
			cmdWrData[m] = PAT[m];
		end
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		test_idle();
		test_sizes();
		test_errors();
		test_both();
		test_reset();
		tally_and_finish();
	end
endmodule
